//--- verilog/trip_action_pkg.sv
// Shared types and encodings for the expansion input trip decision logic.
package trip_action_pkg;

  localparam int SLOT_COUNT = 4;
  localparam int SETPOINT_W = 16;

  typedef enum logic [2:0] {
    MODE_DISPLAY = 3'h0,
    MODE_ALARM = 3'h1,
    MODE_WAIT = 3'h2,
    MODE_WARNING = 3'h3,
    MODE_MAIN_PERMIT = 3'h4,
    MODE_AIRFLOW = 3'h5
  } input_mode_t;

  typedef enum logic [2:0] {
    TR_NONE = 3'h0,
    TR_ALARM = 3'h1,
    TR_LOCKOUT = 3'h2,
    TR_WAITING = 3'h3,
    TR_PILOT = 3'h4,
    TR_PURGE = 3'h5,
    TR_REIGNITE = 3'h6
  } transition_t;

  typedef enum logic [2:0] {
    AL_NONE = 3'h0,
    AL_OPEN_ALARM = 3'h1,
    AL_OPEN_WAIT = 3'h2,
    AL_OPEN_WARNING = 3'h3,
    AL_MAIN_PERMIT = 3'h4
  } alert_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_WAIT = 2'h1,
    SEQ_PURGE = 2'h2,
    SEQ_IGNITE = 2'h3
  } pilot_seq_t;

  localparam logic SEL_RESET = 1'b0;

endpackage : trip_action_pkg

//--- verilog/redundant_slot_select.sv
// Picks the card slot that first reported communication and follows only that slot.
`timescale 1ns/1ps
module redundant_slot_select #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N-1:0] slot_comm_ok,
  input wire logic [N-1:0] slot_energized,
  output logic sel_energized_q,
  output logic locked_q
);

  localparam int IDX_W = (N > 1) ? $clog2(N) : 1;

  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  logic locked_d;
  logic sel_energized_d;

  always_comb begin
    idx_d = idx_q;
    locked_d = locked_q;
    sel_energized_d = sel_energized_q;
    if (!locked_q) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (slot_comm_ok[i]) begin
          idx_d = IDX_W'(i);
          locked_d = 1'b1;
        end
      end
    end
    // A silent slot keeps its last state so that redundancy never stops the burner.
    if (locked_d && slot_comm_ok[idx_d]) begin
      sel_energized_d = slot_energized[idx_d];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_q <= '0;
      locked_q <= 1'b0;
      sel_energized_q <= trip_action_pkg::SEL_RESET;
    end else begin
      idx_q <= idx_d;
      locked_q <= locked_d;
      sel_energized_q <= sel_energized_d;
    end
  end

  a_slot_held: assert property (@(posedge clk_sys) disable iff (rst)
    locked_q |=> locked_q && idx_q == $past(idx_q))
    else $error("Chosen slot changed after lock.");

  a_comm_loss_hold: assert property (@(posedge clk_sys) disable iff (rst)
    locked_q && !slot_comm_ok[idx_q] |=> sel_energized_q == $past(sel_energized_q))
    else $error("Selected state moved while chosen slot was silent.");

endmodule : redundant_slot_select

//--- verilog/expansion_input_trip_action.sv
// Maps a logical expansion digital input to a sequencer transition and an alert.
`timescale 1ns/1ps

module expansion_input_trip_action #(
  parameter int N = trip_action_pkg::SLOT_COUNT,
  parameter int SW = trip_action_pkg::SETPOINT_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N-1:0] slot_energized_pin,
  input wire logic [N-1:0] slot_comm_ok,
  input wire trip_action_pkg::input_mode_t input_mode,
  input wire logic ctrl_running,
  input wire logic ctrl_main_fuel,
  input wire logic pilot_off_after_main,
  input wire logic purge_done,
  input wire logic reignite_done,
  input wire logic split_transmitter,
  input wire logic [SW-1:0] high_trip_setpoint,
  input wire logic [SW-1:0] span_high_cfg,
  output trip_action_pkg::transition_t transition_q,
  output trip_action_pkg::alert_t alert_q,
  output logic input_energized_q,
  output logic [SW-1:0] span_top_q
);

  logic [N-1:0] pin_meta_q;
  logic [N-1:0] pin_sync_q;
  logic sel_energized;
  logic slot_locked;
  trip_action_pkg::transition_t transition_d;
  trip_action_pkg::alert_t alert_d;
  trip_action_pkg::pilot_seq_t seq_q;
  trip_action_pkg::pilot_seq_t seq_d;
  logic [SW-1:0] span_top_d;

  // Field pins are asynchronous to the controller clock.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= slot_energized_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  redundant_slot_select #(
    .N(N)
  ) u_slot_select (
    .clk_sys(clk_sys),
    .rst(rst),
    .slot_comm_ok(slot_comm_ok),
    .slot_energized(pin_sync_q),
    .sel_energized_q(sel_energized),
    .locked_q(slot_locked)
  );

  always_comb begin
    transition_d = trip_action_pkg::TR_NONE;
    alert_d = trip_action_pkg::AL_NONE;
    seq_d = seq_q;
    if (!sel_energized) begin
      unique case (input_mode)
        trip_action_pkg::MODE_ALARM: begin
          transition_d = ctrl_running ? trip_action_pkg::TR_LOCKOUT
                                      : trip_action_pkg::TR_ALARM;
          alert_d = trip_action_pkg::AL_OPEN_ALARM;
        end
        trip_action_pkg::MODE_WAIT: begin
          transition_d = ctrl_running ? trip_action_pkg::TR_WAITING
                                      : trip_action_pkg::TR_NONE;
          alert_d = trip_action_pkg::AL_OPEN_WAIT;
        end
        trip_action_pkg::MODE_WARNING: begin
          alert_d = trip_action_pkg::AL_OPEN_WARNING;
        end
        trip_action_pkg::MODE_MAIN_PERMIT: begin
          alert_d = trip_action_pkg::AL_MAIN_PERMIT;
          if (ctrl_main_fuel) begin
            if (pilot_off_after_main) begin
              transition_d = trip_action_pkg::TR_WAITING;
              if (seq_q == trip_action_pkg::SEQ_IDLE) begin
                seq_d = trip_action_pkg::SEQ_WAIT;
              end
            end else begin
              transition_d = trip_action_pkg::TR_PILOT;
            end
          end
        end
        // Display only, and airflow proving which another block decides.
        default: begin
          transition_d = trip_action_pkg::TR_NONE;
        end
      endcase
    end
    // Once started, the relight sequence owns the transition output until pilot.
    unique case (seq_q)
      trip_action_pkg::SEQ_IDLE: begin
      end
      trip_action_pkg::SEQ_WAIT: begin
        transition_d = trip_action_pkg::TR_WAITING;
        seq_d = trip_action_pkg::SEQ_PURGE;
      end
      trip_action_pkg::SEQ_PURGE: begin
        transition_d = trip_action_pkg::TR_PURGE;
        if (purge_done) begin
          seq_d = trip_action_pkg::SEQ_IGNITE;
        end
      end
      trip_action_pkg::SEQ_IGNITE: begin
        transition_d = trip_action_pkg::TR_REIGNITE;
        if (reignite_done) begin
          transition_d = trip_action_pkg::TR_PILOT;
          seq_d = trip_action_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    span_top_d = split_transmitter ? high_trip_setpoint : span_high_cfg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transition_q <= trip_action_pkg::TR_NONE;
      alert_q <= trip_action_pkg::AL_NONE;
      seq_q <= trip_action_pkg::SEQ_IDLE;
      input_energized_q <= trip_action_pkg::SEL_RESET;
      span_top_q <= '0;
    end else begin
      transition_q <= transition_d;
      alert_q <= alert_d;
      seq_q <= seq_d;
      input_energized_q <= sel_energized;
      span_top_q <= span_top_d;
    end
  end

  sequence s_permit_drop;
    !sel_energized && input_mode == trip_action_pkg::MODE_MAIN_PERMIT && ctrl_main_fuel;
  endsequence

  sequence s_relight_start;
    transition_q == trip_action_pkg::TR_WAITING ##1 transition_q == trip_action_pkg::TR_WAITING
      ##1 transition_q == trip_action_pkg::TR_PURGE;
  endsequence

  a_alarm_stopped: assert property (@(posedge clk_sys) disable iff (rst)
    !sel_energized && input_mode == trip_action_pkg::MODE_ALARM && !ctrl_running
      && seq_q == trip_action_pkg::SEQ_IDLE
    |=> transition_q == trip_action_pkg::TR_ALARM && alert_q == trip_action_pkg::AL_OPEN_ALARM)
    else $error("Alarm mode open while stopped did not alarm.");

  a_alarm_running: assert property (@(posedge clk_sys) disable iff (rst)
    !sel_energized && input_mode == trip_action_pkg::MODE_ALARM && ctrl_running
      && seq_q == trip_action_pkg::SEQ_IDLE
    |=> transition_q == trip_action_pkg::TR_LOCKOUT && alert_q == trip_action_pkg::AL_OPEN_ALARM)
    else $error("Alarm mode open while running did not lock out.");

  a_wait_mode: assert property (@(posedge clk_sys) disable iff (rst)
    !sel_energized && input_mode == trip_action_pkg::MODE_WAIT
      && seq_q == trip_action_pkg::SEQ_IDLE
    |=> alert_q == trip_action_pkg::AL_OPEN_WAIT
      && (transition_q == trip_action_pkg::TR_WAITING) == $past(ctrl_running))
    else $error("Wait mode open gave the wrong reaction.");

  a_warning_only: assert property (@(posedge clk_sys) disable iff (rst)
    !sel_energized && input_mode == trip_action_pkg::MODE_WARNING
      && seq_q == trip_action_pkg::SEQ_IDLE
    |=> transition_q == trip_action_pkg::TR_NONE && alert_q == trip_action_pkg::AL_OPEN_WARNING)
    else $error("Warning mode open caused a transition.");

  a_permit_pilot: assert property (@(posedge clk_sys) disable iff (rst)
    s_permit_drop and (!pilot_off_after_main && seq_q == trip_action_pkg::SEQ_IDLE)
    |=> transition_q == trip_action_pkg::TR_PILOT && alert_q == trip_action_pkg::AL_MAIN_PERMIT)
    else $error("Permissive drop during main fuel did not go to pilot.");

  a_permit_non_main: assert property (@(posedge clk_sys) disable iff (rst)
    !sel_energized && input_mode == trip_action_pkg::MODE_MAIN_PERMIT && !ctrl_main_fuel
      && seq_q == trip_action_pkg::SEQ_IDLE
    |=> transition_q == trip_action_pkg::TR_NONE && alert_q == trip_action_pkg::AL_MAIN_PERMIT)
    else $error("Permissive drop outside main fuel caused a transition.");

  a_relight_wait: assert property (@(posedge clk_sys) disable iff (rst)
    s_permit_drop and (pilot_off_after_main && seq_q == trip_action_pkg::SEQ_IDLE)
    |=> s_relight_start)
    else $error("Pilot off drop did not wait before purge.");

  a_purge_then_ignite: assert property (@(posedge clk_sys) disable iff (rst)
    seq_q == trip_action_pkg::SEQ_PURGE && purge_done
    |=> ##1 transition_q == trip_action_pkg::TR_REIGNITE)
    else $error("Reignite did not follow purge.");

  a_purge_hold: assert property (@(posedge clk_sys) disable iff (rst)
    seq_q == trip_action_pkg::SEQ_PURGE && !purge_done
    |=> seq_q == trip_action_pkg::SEQ_PURGE && transition_q == trip_action_pkg::TR_PURGE)
    else $error("Purge ended before purge done.");

  a_ignite_pilot: assert property (@(posedge clk_sys) disable iff (rst)
    seq_q == trip_action_pkg::SEQ_IGNITE && reignite_done
    |=> transition_q == trip_action_pkg::TR_PILOT && seq_q == trip_action_pkg::SEQ_IDLE)
    else $error("Pilot did not follow reignite.");

  a_energized_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (sel_energized || input_mode == trip_action_pkg::MODE_DISPLAY)
      && input_mode != trip_action_pkg::MODE_AIRFLOW && seq_q == trip_action_pkg::SEQ_IDLE
    |=> transition_q == trip_action_pkg::TR_NONE && alert_q == trip_action_pkg::AL_NONE)
    else $error("Quiet input produced a reaction.");

  a_split_top: assert property (@(posedge clk_sys) disable iff (rst)
    split_transmitter |=> span_top_q == $past(high_trip_setpoint))
    else $error("Split transmitter top is not the high trip setpoint.");

endmodule : expansion_input_trip_action

//--- verif/field_switch_model.sv
// Behavioural field switches and card links standing at the expansion input slots.
`timescale 1ns/1ps
module field_switch_model #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic [N-1:0] want_energized,
  input wire logic [N-1:0] want_comm,
  output logic [N-1:0] slot_energized_pin,
  output logic [N-1:0] slot_comm_ok
);
  initial begin
    slot_energized_pin = '0;
    slot_comm_ok = '0;
  end
  // Contacts move 3 ns after each clock edge, so the pin path sees a late input at a fixed phase to the clock.
  always @(posedge clk_sys) begin
    slot_energized_pin <= #3 want_energized;
    slot_comm_ok <= #1 want_comm;
  end
endmodule : field_switch_model

//--- verif/expansion_input_trip_action_bench.sv
// Self-checking bench for the expansion input trip decision logic.
`timescale 1ns/1ps
module expansion_input_trip_action_bench;
  logic clk_sys, rst, run, mf, poff, pdone, rdone, split, energ;
  logic [3:0] want_e, want_c, pins, comm;
  logic [15:0] hi_sp, span_cfg, span_top;
  logic [17:0] n;
  logic [31:0] rnd;
  trip_action_pkg::input_mode_t mode;
  trip_action_pkg::transition_t tr;
  trip_action_pkg::alert_t al;
  logic [17:0] q[$];
  int err_count, checks_done, seed, m, r, f, e, i;
  event look;

  field_switch_model #(.N(4)) u_field (.clk_sys(clk_sys), .want_energized(want_e),
    .want_comm(want_c), .slot_energized_pin(pins), .slot_comm_ok(comm));
  expansion_input_trip_action u_dut (.clk_sys(clk_sys), .rst(rst), .slot_energized_pin(pins),
    .slot_comm_ok(comm), .input_mode(mode), .ctrl_running(run), .ctrl_main_fuel(mf),
    .pilot_off_after_main(poff), .purge_done(pdone), .reignite_done(rdone),
    .split_transmitter(split), .high_trip_setpoint(hi_sp), .span_high_cfg(span_cfg),
    .transition_q(tr), .alert_q(al), .input_energized_q(energ), .span_top_q(span_top));

  task give_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task note(input logic [1:0] k, input logic [15:0] v);
    q.push_back({k, v});
    -> look;
  endtask : note

  task tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick

  // The sequence may run on at once, so the output is looked at before each wait.
  task wait_tr(input trip_action_pkg::transition_t t);
    for (int k = 0; k < 30 && tr !== t; k++) tick(1);
    note(2'h0, {13'h0, t});
  endtask : wait_tr

  function automatic logic [5:0] expect_pair(int m, int r, int f, int e);
    if (e != 0) return 6'h00;
    case (m)
      1: return {(r != 0) ? 3'h2 : 3'h1, 3'h1};
      2: return {(r != 0) ? 3'h3 : 3'h0, 3'h2};
      3: return 6'h03;
      4: return {(f != 0) ? 3'h4 : 3'h0, 3'h4};
      default: return 6'h00;
    endcase
  endfunction : expect_pair

  initial begin
    forever begin
      @(look);
      while (q.size() > 0) begin
        n = q.pop_front();
        case (n[17:16])
          2'h0: check("transition", {13'h0, tr}, n[15:0]);
          2'h1: check("alert", {13'h0, al}, n[15:0]);
          2'h2: check("energized", {15'h0, energ}, n[15:0]);
          default: check("span_top", span_top, n[15:0]);
        endcase
      end
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    err_count++;
    give_verdict();
  end

  initial begin
    seed = 9646;
    rst = 1'b1;
    {run, mf, poff, pdone, rdone, split} = 6'h00;
    want_e = 4'h2;
    want_c = 4'h0;
    mode = trip_action_pkg::MODE_DISPLAY;
    hi_sp = 16'h0000;
    span_cfg = 16'h0000;
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    want_c = 4'h6;
    tick(3);
    want_c = 4'hF;
    // Slots 0, 2 and 3 carry random levels that the selected slot 1 must mask.
    for (m = 0; m < 6; m++) for (r = 0; r < 2; r++) for (f = 0; f < 2; f++)
      for (e = 0; e < 2; e++) begin
        rnd = $random(seed);
        want_e = {rnd[1:0], e[0], rnd[2]};
        mode = trip_action_pkg::input_mode_t'(m[2:0]);
        run = r[0];
        mf = f[0];
        tick(7);
        note(2'h0, {10'h000, expect_pair(m, r, f, e) >> 3});
        note(2'h1, {10'h000, expect_pair(m, r, f, e) & 6'h07});
        note(2'h2, {15'h0, e[0]});
      end
    mode = trip_action_pkg::MODE_ALARM;
    run = 1'b1;
    mf = 1'b0;
    want_e = 4'h2;
    tick(7);
    want_c = 4'hD;
    want_e = 4'h0;
    tick(7);
    note(2'h0, 16'h0000);
    note(2'h2, 16'h0001);
    // The contact must settle through the synchroniser before the slot talks again.
    want_e = 4'h2;
    tick(7);
    want_c = 4'hF;
    mode = trip_action_pkg::MODE_MAIN_PERMIT;
    mf = 1'b1;
    poff = 1'b1;
    tick(7);
    want_e = 4'h0;
    wait_tr(trip_action_pkg::TR_WAITING);
    note(2'h1, {13'h0, trip_action_pkg::AL_MAIN_PERMIT});
    wait_tr(trip_action_pkg::TR_PURGE);
    pdone = 1'b1;
    tick(1);
    pdone = 1'b0;
    wait_tr(trip_action_pkg::TR_REIGNITE);
    rdone = 1'b1;
    tick(1);
    rdone = 1'b0;
    wait_tr(trip_action_pkg::TR_PILOT);
    mode = trip_action_pkg::MODE_DISPLAY;
    poff = 1'b0;
    for (i = 0; i < 4; i++) begin
      hi_sp = 16'($random(seed));
      span_cfg = 16'($random(seed));
      split = i[0];
      tick(2);
      note(2'h3, split ? hi_sp : span_cfg);
    end
    tick(3);
    give_verdict();
  end
endmodule : expansion_input_trip_action_bench
